/* shared/event_flags_pkg.sv */
// Purpose: constants and carrier types for the event flag block
// Assumes: one 32-bit register word per access
// Notes: offsets are word indexes of the serial register map
package event_flags_pkg;

  localparam logic [15:0] EVENT_FLAGS_ADDR = 16'h0402;
  localparam logic [15:0] EVENT_MASK_ADDR  = 16'h0405;
  localparam logic [31:0] EVENT_FLAGS_RST  = 32'h0000_0000;
  localparam logic [31:0] EVENT_MASK_RST   = 32'h0000_0000;

  localparam int CHIP_SUM_BIT    = 31;
  localparam int EVENT_SUM_BIT   = 30;
  localparam int AUTOCAL_SUM_BIT = 29;
  localparam int POWER_FACTOR_READY_FLAG_BIT      = 25;
  localparam int CHECKSUM_CHANGED_FLAG_BIT     = 24;
  localparam int CRC_DONE_BIT    = 23;
  localparam int ZX_TIMEOUT_BIT  = 21;
  localparam int ZX_CUR_B_BIT    = 20;
  localparam int ZX_CUR_A_BIT    = 19;
  localparam int ZX_VOLT_BIT     = 17;
  localparam int RST_DONE_BIT    = 16;
  localparam int REACT_NL_BIT    = 15;
  localparam int APPAR_NL_BIT    = 14;
  localparam int ACTIVE_NL_BIT   = 13;
  localparam int TEMP_RDY_BIT    = 12;
  localparam int RMS_RDY_BIT     = 11;
  localparam int PWR_RDY_BIT     = 10;
  localparam int SAMPLE_RDY_BIT  = 9;
  localparam int ENERGY_RDY_BIT  = 8;
  localparam int PULSE_TWO_BIT   = 7;
  localparam int PULSE_ONE_BIT   = 6;
  localparam int REV_TWO_BIT     = 5;
  localparam int REV_ONE_BIT     = 4;

  // bits that software clears by writing one
  localparam logic [31:0] W1C_MASK     = 32'h03BB_FFF0;
  // bits that the mask register can hold
  localparam logic [31:0] MASK_WR_MASK = 32'h63BA_FF00 | 32'h0000_00F0;

  // one-cycle event pulses from the measurement datapath
  typedef struct packed {
    logic pf_update;
    logic crc_changed;
    logic crc_done;
    logic zx_timeout;
    logic zx_cur_b;
    logic zx_cur_a;
    logic zx_volt;
    logic powerup_done;
    logic react_noload;
    logic appar_noload;
    logic active_noload;
    logic temp_ready;
    logic rms_ready;
    logic power_ready;
    logic sample_ready;
    logic energy_ready;
  } event_pulses_t;

  // register access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // pulse output levels and the sign of the energy they carry
  typedef struct packed {
    logic two_level;
    logic two_neg;
    logic one_level;
    logic one_neg;
  } pulse_pins_t;

endpackage

/* src/metering_event_status_flags.sv */
// Purpose: main event flag register with mask and interrupt output
// Assumes: register requests are one-cycle strobes from the serial port logic
// Notes: read data returns one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module metering_event_status_flags (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire event_flags_pkg::reg_req_t     req_in,
  input  wire event_flags_pkg::event_pulses_t events_in,
  input  wire event_flags_pkg::pulse_pins_t  pins_in,
  input  wire logic                          chip_cond_set_in,
  input  wire logic                          chip_cond_read_in,
  input  wire logic                          event_cond_set_in,
  input  wire logic                          event_cond_read_in,
  input  wire logic                          autocal_cond_set_in,
  input  wire logic                          autocal_cond_read_in,
  output logic [31:0]                        rdata_out,
  output logic                               rvalid_out,
  output logic                               irq_n_out
);

  logic [31:0] flags_r;
  logic [31:0] flags_nxt;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic        irq_n_r;
  logic        irq_n_nxt;
  logic [31:0] set_vec;
  logic [31:0] clr_vec;
  logic [31:0] view;
  logic        chip_sum;
  logic        event_sum;
  logic        autocal_sum;
  logic        pulse_two;
  logic        pulse_one;
  logic        rev_two;
  logic        rev_one;
  logic        flags_hit;
  logic        mask_hit;

  summary_flag u_chip_sum (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .src_set_in  (chip_cond_set_in),
    .src_read_in (chip_cond_read_in),
    .flag_out    (chip_sum)
  );

  summary_flag u_event_sum (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .src_set_in  (event_cond_set_in),
    .src_read_in (event_cond_read_in),
    .flag_out    (event_sum)
  );

  summary_flag u_autocal_sum (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .src_set_in  (autocal_cond_set_in),
    .src_read_in (autocal_cond_read_in),
    .flag_out    (autocal_sum)
  );

  pulse_edge_watch u_watch_two (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .level_in     (pins_in.two_level),
    .neg_in       (pins_in.two_neg),
    .pulse_out    (pulse_two),
    .reversal_out (rev_two)
  );

  pulse_edge_watch u_watch_one (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .level_in     (pins_in.one_level),
    .neg_in       (pins_in.one_neg),
    .pulse_out    (pulse_one),
    .reversal_out (rev_one)
  );

  always_comb begin
    set_vec = 32'h0000_0000;
    set_vec[event_flags_pkg::POWER_FACTOR_READY_FLAG_BIT]     = events_in.pf_update;
    set_vec[event_flags_pkg::CHECKSUM_CHANGED_FLAG_BIT]    = events_in.crc_changed;
    set_vec[event_flags_pkg::CRC_DONE_BIT]   = events_in.crc_done;
    set_vec[event_flags_pkg::ZX_TIMEOUT_BIT] = events_in.zx_timeout;
    set_vec[event_flags_pkg::ZX_CUR_B_BIT]   = events_in.zx_cur_b;
    set_vec[event_flags_pkg::ZX_CUR_A_BIT]   = events_in.zx_cur_a;
    set_vec[event_flags_pkg::ZX_VOLT_BIT]    = events_in.zx_volt;
    set_vec[event_flags_pkg::RST_DONE_BIT]   = events_in.powerup_done;
    set_vec[event_flags_pkg::REACT_NL_BIT]   = events_in.react_noload;
    set_vec[event_flags_pkg::APPAR_NL_BIT]   = events_in.appar_noload;
    set_vec[event_flags_pkg::ACTIVE_NL_BIT]  = events_in.active_noload;
    set_vec[event_flags_pkg::TEMP_RDY_BIT]   = events_in.temp_ready;
    set_vec[event_flags_pkg::RMS_RDY_BIT]    = events_in.rms_ready;
    set_vec[event_flags_pkg::PWR_RDY_BIT]    = events_in.power_ready;
    set_vec[event_flags_pkg::SAMPLE_RDY_BIT] = events_in.sample_ready;
    set_vec[event_flags_pkg::ENERGY_RDY_BIT] = events_in.energy_ready;
    set_vec[event_flags_pkg::PULSE_TWO_BIT]  = pulse_two;
    set_vec[event_flags_pkg::PULSE_ONE_BIT]  = pulse_one;
    set_vec[event_flags_pkg::REV_TWO_BIT]    = rev_two;
    set_vec[event_flags_pkg::REV_ONE_BIT]    = rev_one;

    flags_hit = (req_in.addr == event_flags_pkg::EVENT_FLAGS_ADDR);
    mask_hit  = (req_in.addr == event_flags_pkg::EVENT_MASK_ADDR);

    clr_vec = (req_in.wr && flags_hit) ? (req_in.wdata & event_flags_pkg::W1C_MASK)
                                       : 32'h0000_0000;
    flags_nxt = ((flags_r & ~clr_vec) | set_vec) & event_flags_pkg::W1C_MASK;

    mask_nxt = (req_in.wr && mask_hit) ? (req_in.wdata & event_flags_pkg::MASK_WR_MASK)
                                       : mask_r;

    view = flags_r;
    view[event_flags_pkg::CHIP_SUM_BIT]    = chip_sum;
    view[event_flags_pkg::EVENT_SUM_BIT]   = event_sum;
    view[event_flags_pkg::AUTOCAL_SUM_BIT] = autocal_sum;

    rvalid_nxt = req_in.rd;
    if (req_in.rd && flags_hit) begin
      rdata_nxt = view;
    end else if (req_in.rd && mask_hit) begin
      rdata_nxt = mask_r;
    end else begin
      rdata_nxt = 32'h0000_0000;
    end

    irq_n_nxt = ~|(view & mask_r);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flags_r  <= event_flags_pkg::EVENT_FLAGS_RST;
      mask_r   <= event_flags_pkg::EVENT_MASK_RST;
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      irq_n_r  <= 1'b1;
    end else begin
      flags_r  <= flags_nxt;
      mask_r   <= mask_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      irq_n_r  <= irq_n_nxt;
    end
  end

  assign rdata_out  = rdata_r;
  assign rvalid_out = rvalid_r;
  assign irq_n_out  = irq_n_r;

endmodule
`default_nettype wire

/* src/pulse_edge_watch.sv */
// Purpose: falling edge and sign reversal detector for one pulse output
// Assumes: pulse level and sign synchronous to mclk_in
// Notes: first pulse after reset never counts as a reversal
`timescale 1ns/1ps
`default_nettype none
module pulse_edge_watch (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic level_in,
  input  wire logic neg_in,
  output logic      pulse_out,
  output logic      reversal_out
);

  logic level_r;
  logic level_nxt;
  logic last_neg_r;
  logic last_neg_nxt;
  logic seen_r;
  logic seen_nxt;
  logic fall;

  always_comb begin
    fall         = level_r & ~level_in;
    level_nxt    = level_in;
    last_neg_nxt = fall ? neg_in : last_neg_r;
    seen_nxt     = seen_r | fall;
    pulse_out    = fall;
    reversal_out = fall & seen_r & (neg_in != last_neg_r);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      level_r    <= 1'b0;
      last_neg_r <= 1'b0;
      seen_r     <= 1'b0;
    end else begin
      level_r    <= level_nxt;
      last_neg_r <= last_neg_nxt;
      seen_r     <= seen_nxt;
    end
  end

endmodule
`default_nettype wire

/* src/summary_flag.sv */
// Purpose: summary bit that mirrors another status register
// Assumes: read strobe of that register is a one-cycle pulse
// Notes: a new source bit on the read cycle keeps the flag set
`timescale 1ns/1ps
`default_nettype none
module summary_flag (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic src_set_in,
  input  wire logic src_read_in,
  output logic      flag_out
);

  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = src_set_in | (flag_r & ~src_read_in);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;

endmodule
`default_nettype wire

/* testbench/event_flags_chk.sv */
// Purpose: port checker for the event flag block
// Assumes: one clock, synchronous active-low reset
// Notes: flag reads are checked two cycles after their cause
`timescale 1ns/1ps
`default_nettype none
module event_flags_chk (
  input wire logic                           mclk_in,
  input wire logic                           rst_n_in,
  input wire event_flags_pkg::reg_req_t      req_in,
  input wire event_flags_pkg::event_pulses_t events_in,
  input wire event_flags_pkg::pulse_pins_t   pins_in,
  input wire logic                           chip_cond_set_in,
  input wire logic                           chip_cond_read_in,
  input wire logic                           event_cond_set_in,
  input wire logic                           event_cond_read_in,
  input wire logic [31:0]                    rdata_out,
  input wire logic                           rvalid_out,
  input wire logic                           irq_n_out
);
  localparam logic [15:0] FA = event_flags_pkg::EVENT_FLAGS_ADDR;
  localparam logic [15:0] MA = event_flags_pkg::EVENT_MASK_ADDR;
  logic rf;
  assign rf = req_in.rd && !req_in.wr && req_in.addr == FA;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence flag_rd;
    !req_in.wr ##1 rf;
  endsequence
  rst_vals_a: assert property ($rose(rst_n_in) |-> irq_n_out && !rvalid_out)
    else $error("outputs not idle after reset");
  rd_valid_a: assert property (req_in.rd |=> rvalid_out)
    else $error("read not answered");
  rd_idle_a: assert property (!rvalid_out |-> rdata_out == '0)
    else $error("read data not zero when idle");
  unmapped_zero_a: assert property (rvalid_out && $past(req_in.addr) != FA
    && $past(req_in.addr) != MA |-> rdata_out == '0) else $error("unmapped read not zero");
  resv_zero_a: assert property (rvalid_out && $past(req_in.addr) == FA
    |-> (rdata_out & 32'h1C44_000F) == '0) else $error("reserved bit read one");
  sample_set_a: assert property (events_in.sample_ready ##1 flag_rd |=> rdata_out[9])
    else $error("sample flag not set");
  pulse_set_a: assert property ($fell(pins_in.one_level) ##1 flag_rd |=> rdata_out[6])
    else $error("pulse flag not set");
  sum_set_a: assert property (chip_cond_set_in ##1 !chip_cond_read_in ##0 flag_rd
    |=> rdata_out[31]) else $error("chip summary not set");
  sum_clear_a: assert property ((event_cond_read_in && !event_cond_set_in)
    ##1 !event_cond_set_in ##1 (rf && !event_cond_set_in) |=> !rdata_out[30])
    else $error("event summary not cleared");
  irq_off_a: assert property (req_in.wr && req_in.addr == MA && req_in.wdata == '0
    |-> ##2 irq_n_out) else $error("interrupt with empty mask");
endmodule
bind metering_event_status_flags event_flags_chk u_chk (.mclk_in(mclk_in),
  .rst_n_in(rst_n_in), .req_in(req_in), .events_in(events_in), .pins_in(pins_in),
  .chip_cond_set_in(chip_cond_set_in), .chip_cond_read_in(chip_cond_read_in),
  .event_cond_set_in(event_cond_set_in),
  .event_cond_read_in(event_cond_read_in), .rdata_out(rdata_out),
  .rvalid_out(rvalid_out), .irq_n_out(irq_n_out));
`default_nettype wire

/* testbench/host_model.sv */
// Purpose: host model issuing register strobes
// Assumes: strobes change at the falling clock edge
// Notes: address and data lines drift while the bus is idle
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic                      mclk_in,
  output var event_flags_pkg::reg_req_t req_out
);
  initial req_out = '0;
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk_in);
    req_out = {~w, w, a, d};
    @(negedge mclk_in);
    req_out = {2'b00, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for the event flag block
// Assumes: inputs change at the falling clock edge
// Notes: read results are matched against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] FA = event_flags_pkg::EVENT_FLAGS_ADDR;
  localparam logic [15:0] MA = event_flags_pkg::EVENT_MASK_ADDR;
  logic                           mclk_in = 1'b0;
  logic                           rst_n_in = 1'b0;
  event_flags_pkg::reg_req_t      req;
  event_flags_pkg::event_pulses_t ev = '0;
  event_flags_pkg::pulse_pins_t   pins = '0;
  logic [2:0]                     ss = '0;
  logic [2:0]                     sr = '0;
  logic [31:0]                    rdata;
  logic                           rvalid;
  logic                           irq_n;
  logic [31:0]                    q[$];
  logic [31:0]                    seed = 32'hEE0F_A783;
  logic [31:0]                    exp;
  logic [31:0]                    w;
  int                             num_errors = 0;
  int                             checked = 0;
  int pos[16] = '{8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 19, 20, 21, 23, 24, 25};
  always #2.5 mclk_in = ~mclk_in;
  host_model u_host (.mclk_in(mclk_in), .req_out(req));
  metering_event_status_flags u_metering_event_status_flags (.mclk_in(mclk_in),
    .rst_n_in(rst_n_in), .req_in(req), .events_in(ev), .pins_in(pins),
    .chip_cond_set_in(ss[2]), .chip_cond_read_in(sr[2]), .event_cond_set_in(ss[1]),
    .event_cond_read_in(sr[1]), .autocal_cond_set_in(ss[0]), .autocal_cond_read_in(sr[0]),
    .rdata_out(rdata), .rvalid_out(rvalid), .irq_n_out(irq_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    q.push_back(e);
    u_host.access(1'b0, a, '0);
  endtask
  task automatic strobe(input logic [15:0] e, input logic [2:0] s, input logic [2:0] r);
    @(negedge mclk_in);
    ev = e;
    ss = s;
    sr = r;
    @(negedge mclk_in);
    ev = '0;
    ss = '0;
    sr = '0;
  endtask
  task automatic fall(input logic neg);
    @(negedge mclk_in);
    pins = {1'b1, neg, 1'b1, neg};
    @(negedge mclk_in);
    pins = {1'b0, neg, 1'b0, neg};
    @(negedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    #1;
    if (rvalid === 1'b1) begin
      if (q.size() == 0) check(rdata, 32'hFFFF_FFFF);
      else check(rdata, q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    rst_n_in = 1'b1;
    rd(FA, '0);
    rd(MA, '0);
    u_host.access(1'b1, 16'h0403, '1);
    rd(16'h0403, '0);
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      exp = '0;
      for (int i = 0; i < 16; i++) begin
        if (seed[i]) exp[pos[i]] = 1'b1;
      end
      strobe(seed[15:0], '0, '0);
      rd(FA, exp);
      w = xs(seed);
      u_host.access(1'b1, FA, w);
      rd(FA, exp & ~w);
      u_host.access(1'b1, FA, '1);
    end
    fall(1'b0);
    rd(FA, 32'h0000_00C0);
    u_host.access(1'b1, FA, '1);
    fall(1'b0);
    rd(FA, 32'h0000_00C0);
    u_host.access(1'b1, FA, '1);
    fall(1'b1);
    rd(FA, 32'h0000_00F0);
    u_host.access(1'b1, FA, '1);
    for (int i = 0; i < 3; i++) begin
      strobe('0, 3'b001 << i, '0);
      rd(FA, 32'h1 << (29 + i));
      u_host.access(1'b1, FA, '1);
      rd(FA, 32'h1 << (29 + i));
      strobe('0, '0, 3'b001 << i);
      rd(FA, '0);
    end
    w = xs(w);
    u_host.access(1'b1, MA, w);
    rd(MA, w & event_flags_pkg::MASK_WR_MASK);
    u_host.access(1'b1, MA, 32'h0000_0200);
    strobe(16'h0002, '0, '0);
    @(negedge mclk_in);
    check(irq_n, 1'b0);
    u_host.access(1'b1, FA, 32'h0000_0200);
    repeat (2) @(negedge mclk_in);
    check(irq_n, 1'b1);
    u_host.access(1'b1, MA, '0);
    repeat (4) @(negedge mclk_in);
    check(32'(q.size()), '0);
    end_sim();
  end
endmodule
`default_nettype wire
